/* File: aux_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module aux_chk
  import aux_pkg::*;
#(
  parameter int unsigned MAX_LEN = MAX_CHARS
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Watched ports.
  input wire logic term_txd,
  input wire logic aux_mode_set,
  input wire logic aux_mode_clr,
  input wire logic aux_mode,
  input wire logic reading_pulse,
  input wire logic res_start,
  input wire logic res_valid,
  input wire logic [7:0] res_data,
  input wire logic res_last,
  input wire logic [3:0] result_status_field,
  input wire logic res_ready,
  input wire logic [5:0] held_len
);
  // All checks share the one clock domain.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  chk_no_echo:
    assert property (term_txd) else $error("echo on terminal line");
  chk_len_cap:
    assert property (held_len <= MAX_LEN) else $error("string too long");
  chk_status_code:
    assert property (res_start |-> result_status_field == AUX_STATUS) else $error("wrong status");
  chk_after_pulse:
    assert property (res_start |-> !$past(reading_pulse)) else $error("sent during pulse");
  chk_byte_hold:
    assert property (res_valid && !res_ready |=> res_valid && $stable(res_data) && $stable(res_last))
      else $error("byte not held");
  chk_start_single:
    assert property (res_start |-> res_valid ##1 !res_start) else $error("bad start pulse");
  chk_mode_on:
    assert property (aux_mode_set |=> aux_mode) else $error("mode not set");
  chk_mode_off:
    assert property (aux_mode_clr && !aux_mode_set |=> !aux_mode) else $error("mode not cleared");
  chk_valid_drop:
    assert property (res_valid && res_ready && res_last |=> !res_valid) else $error("valid held after last");
endmodule : aux_chk
bind aux_serial_result_injector aux_chk #(.MAX_LEN(MAX_LEN)) chk_u (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .term_txd(term_txd),
  .aux_mode_set(aux_mode_set),
  .aux_mode_clr(aux_mode_clr),
  .aux_mode(aux_mode),
  .reading_pulse(reading_pulse),
  .res_start(res_start),
  .res_valid(res_valid),
  .res_data(res_data),
  .res_last(res_last),
  .result_status_field(result_status_field),
  .res_ready(res_ready),
  .held_len(held_len)
);
`default_nettype wire

/* File: aux_pkg.sv */
package aux_pkg;
  // Serial link: 9600 baud, 8 data bits, no parity, one stop bit.
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned BAUD_RATE = 9600;
  localparam int unsigned BIT_CYCLES = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned STOP_BITS = 1;
  // Longest injected string in characters.
  localparam int unsigned MAX_CHARS = 50;
  // Status code written into an injected result.
  localparam logic [3:0] AUX_STATUS = 4'h7;
  // Character codes.
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_SPACE = 8'h20;
  localparam logic [7:0] CHAR_DEL = 8'h7F;
  // Reset value of the auxiliary mode flag.
  localparam logic AUX_MODE_RESET = 1'b0;
endpackage : aux_pkg

/* File: aux_serial_result_injector.sv */
// Functional notes
// - Link is 9600 baud, 8N1.
// - At most 50 characters per string.
// - Status field set to 7 when enabled.
// - CR ends string; next char starts new.
// - Other control characters are discarded.
// - No echo on the terminal link.
// - Send only after reading pulse ends.
// - Same framing as normal reading results.
// - Other diagnostic fields carry no meaning.
// - Accept content only in auxiliary mode.
// - Temporary mode lost at power down.
`timescale 1ns/1ps
`default_nettype none
module aux_serial_result_injector
  import aux_pkg::*;
#(
  parameter int unsigned MAX_LEN = MAX_CHARS,
  parameter int unsigned BIT_CYC = BIT_CYCLES
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Terminal serial port.
  input wire logic term_rxd,
  output logic term_txd,
  // Mode control: temporary auxiliary mode set and clear strobes.
  input wire logic aux_mode_set,
  input wire logic aux_mode_clr,
  output logic aux_mode,
  // Reading pulse and status transmission enable.
  input wire logic reading_pulse,
  input wire logic err_status_en,
  // Result stream towards the host formatter.
  output logic res_start,
  output logic res_valid,
  output logic [7:0] res_data,
  output logic res_last,
  output logic [3:0] result_status_field,
  output logic result_status_valid,
  output logic [7:0] result_diag,
  input wire logic res_ready,
  // Count of characters held.
  output logic [5:0] held_len
);
  // Writer states, one-hot.
  typedef enum logic [2:0] {
    // Nothing to send.
    SEND_IDLE = 3'b001,
    // A string is held until the reading pulse has ended.
    SEND_HOLD = 3'b010,
    // Bytes are going out to the host formatter.
    SEND_BUSY = 3'b100
  } send_state_t;

  // Printable test shared by the storage path.
  function automatic logic is_printable(input logic [7:0] c);
    // Codes below space and the delete code count as control characters.
    is_printable = (c >= CHAR_SPACE) && (c != CHAR_DEL);
  endfunction : is_printable

  // Receiver output.
  logic [7:0] rx_data;
  logic rx_valid;
  // Collecting string storage and length.
  logic [7:0] col_mem [MAX_LEN];
  // Six bits cover the default longest string.
  logic [5:0] col_len_reg;
  // Completed string waiting for output.
  logic [7:0] out_mem [MAX_LEN];
  logic [5:0] out_len_reg;
  // High while the output slot holds a string.
  logic pend_reg;
  // Output position and state.
  // Index of the next character to show.
  logic [5:0] pos_reg;
  // Writer state.
  send_state_t state_reg;
  // Carriage return received while auxiliary mode is on.
  logic term_hit;
  logic take_out;
  // Writer starts a result in this cycle.
  logic send_go;
  // The formatter takes the byte on show in this cycle.
  logic byte_take;

  // Bit timing comes from the parameter, so a test may use a short bit.
  // serial receiver
  aux_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .rxd(term_rxd),
    .rx_data(rx_data),
    .rx_valid(rx_valid)
  );

  // no echo: the transmit line stays idle high.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      term_txd <= 1'b1;
    end else begin
      // Nothing is ever sent back; received characters only go to the host.
      term_txd <= 1'b1;
    end
  end

  // Mode flag: set wins over clear; reset returns the stored (off) mode.
  // The temporary setting is not kept anywhere, so a restart always begins off.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      aux_mode <= AUX_MODE_RESET;
    end else if (aux_mode_set) begin
      // A set strobe wins when both arrive together.
      aux_mode <= 1'b1;
    end else if (aux_mode_clr) begin
      // Back to normal terminal use.
      aux_mode <= 1'b0;
    end
  end

  // A carriage return only counts while auxiliary mode is on.
  // terminator detection
  assign term_hit = aux_mode && rx_valid && (rx_data == CHAR_CR);
  // The completed string moves across only when the output slot is free.
  assign take_out = term_hit && !pend_reg && (col_len_reg != 6'h00);
  // Start of a result: a string is held and the reading pulse is over.
  assign send_go = (state_reg == SEND_HOLD) && !reading_pulse;
  // One result byte changes hands.
  assign byte_take = (state_reg == SEND_BUSY) && res_valid && res_ready;

  // Collect characters of the current string.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      col_len_reg <= 6'h00;
    end else if (term_hit) begin
      // A new string starts after the terminator.  If the slot is busy,
      // the string is lost: with one slot, holding two would need a queue.
      col_len_reg <= 6'h00;
    end else if (aux_mode && rx_valid) begin
      if (is_printable(rx_data) && (col_len_reg < 6'(MAX_LEN))) begin
        col_len_reg <= col_len_reg + 6'h01;
      end
      // Control codes and characters past the limit leave the count as it is.
    end
  end

  // Character storage for the collecting string.
  // No reset here: the length counter alone says which entries are valid.
  always_ff @(posedge clk_sys) begin
    if (aux_mode && rx_valid && is_printable(rx_data) && (col_len_reg < 6'(MAX_LEN))) begin
      col_mem[col_len_reg] <= rx_data;
    end
  end

  // Copy the finished string into the output slot.
  // The whole array moves in one cycle, so a new string may start at once.
  always_ff @(posedge clk_sys) begin
    if (take_out) begin
      out_mem <= col_mem;
    end
  end

  // Output slot length.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      out_len_reg <= 6'h00;
    end else if (take_out) begin
      // Taken together with the copied characters.
      out_len_reg <= col_len_reg;
    end
  end

  // Pending flag: set on a new string, cleared after the last byte leaves.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pend_reg <= 1'b0;
    end else if (take_out) begin
      pend_reg <= 1'b1;
    end else if (byte_take && res_last) begin
      // The slot frees up as the last byte is taken.
      pend_reg <= 1'b0;
    end
  end

  // Writer sequence: wait for the pulse to end, then stream the string.
  // Only the state lives here; the result outputs come from the processes below, the status fields from one shared process.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= SEND_IDLE;
    end else begin
      case (state_reg)
        SEND_IDLE: begin
          // A held string moves the writer on.
          if (pend_reg) begin
            state_reg <= SEND_HOLD;
          end
        end
        SEND_HOLD: begin
          if (!reading_pulse) begin
            state_reg <= SEND_BUSY;
          end
        end
        SEND_BUSY: begin
          // The last byte taken ends the result.
          if (res_ready && res_last) begin
            state_reg <= SEND_IDLE;
          end
        end
        default: begin
          // An illegal code falls back to idle.
          state_reg <= SEND_IDLE;
        end
      endcase
    end
  end

  // Start marker: one cycle, together with the first byte.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      res_start <= 1'b0;
    end else begin
      res_start <= send_go;
    end
  end

  // Valid flag: up from the start until the last byte is taken.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      res_valid <= 1'b0;
    end else if (send_go) begin
      res_valid <= 1'b1;
    end else if (byte_take && res_last) begin
      // The formatter has the whole string.
      res_valid <= 1'b0;
    end
  end

  // Read position and data byte; a stalled byte stays on show unchanged.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pos_reg <= 6'h00;
      res_data <= 8'h00;
    end else if (send_go) begin
      // The first byte goes out with the start marker.
      res_data <= out_mem[0];
      pos_reg <= 6'h01;
    end else if (byte_take && !res_last) begin
      // Step to the next stored character.
      res_data <= out_mem[pos_reg];
      pos_reg <= pos_reg + 6'h01;
    end
  end

  // Last-byte marker, worked out one byte ahead of need.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      res_last <= 1'b0;
    end else if (send_go) begin
      // A one-character string is first and last at once.
      res_last <= (out_len_reg == 6'h01);
    end else if (byte_take) begin
      // After the last byte the marker drops with the valid flag.
      res_last <= !res_last && (pos_reg + 6'h01 == out_len_reg);
    end
  end

  // Status and diagnostic fields that go with the result.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      result_status_field <= 4'h0;
      result_status_valid <= 1'b0;
      result_diag <= 8'h00;
    end else if (send_go) begin
      // Fields are latched once per result and then stand until the next one.
      // status seven
      result_status_field <= AUX_STATUS;
      result_status_valid <= err_status_en;
      result_diag <= 8'h00;
    end
  end

  // Length of the string being collected, visible for monitoring.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      held_len <= 6'h00;
    end else begin
      // One cycle behind the counter, as every output comes from a flip-flop.
      held_len <= col_len_reg;
    end
  end
endmodule : aux_serial_result_injector
`default_nettype wire

/* File: aux_serial_result_injector_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module aux_serial_result_injector_tb_top;
  import aux_pkg::*;
  // Short bit time keeps the run brief.
  localparam int unsigned BC = 8;
  logic clk_sys = 0, rstn = 0, rxd, ms = 0, mc = 0, rp = 0, ee = 1, rdy = 1;
  logic txd, mode, rs, rv, rl, sv;
  logic [3:0] sf;
  logic [7:0] rd, dg;
  logic [5:0] hl;
  int error_cnt = 0;
  int n_compared = 0;
  initial forever #50 clk_sys = ~clk_sys;
  aux_serial_result_injector #(.BIT_CYC(BC)) dut_u (.clk_sys(clk_sys), .rstn(rstn), .term_rxd(rxd),
    .term_txd(txd), .aux_mode_set(ms), .aux_mode_clr(mc), .aux_mode(mode), .reading_pulse(rp),
    .err_status_en(ee), .res_start(rs), .res_valid(rv), .res_data(rd), .res_last(rl),
    .result_status_field(sf), .result_status_valid(sv), .result_diag(dg), .res_ready(rdy), .held_len(hl));
  aux_term_model #(.BIT_CYC(BC)) model_u (.clk_sys(clk_sys), .txd(rxd));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  // Drains one result through a consumer that stalls every other cycle.
  task automatic take(input logic [7:0] e[$], input logic sv_exp);
    int i;
    int n;
    i = 0;
    n = 0;
    while (rv !== 1'b1) begin
      @(negedge clk_sys);
      if (++n > 3000) begin
        error_cnt++;
        tally_and_finish();
      end
    end
    chk({7'h0, rs}, 8'h01);
    chk({4'h0, sf}, {4'h0, AUX_STATUS});
    chk({7'h0, sv}, {7'h0, sv_exp});
    chk(dg, 8'h00);
    while (i < e.size()) begin
      if (rv === 1'b1 && rdy) begin
        chk(rd, e[i]);
        chk({7'h0, rl}, {7'h0, i == e.size() - 1});
        i++;
      end
      @(negedge clk_sys);
      rdy = ~rdy;
      if (++n > 3000) begin
        error_cnt++;
        tally_and_finish();
      end
    end
    rdy = 1;
    @(negedge clk_sys);
    chk({7'h0, rv}, 8'h00);
  endtask : take
  task automatic mode_on();
    ms = 1;
    @(negedge clk_sys);
    ms = 0;
  endtask : mode_on
  // Characters in normal mode are not taken.
  task automatic t_mode_off();
    chk({7'h0, mode}, 8'h00);
    chk({7'h0, txd}, 8'h01);
    model_u.send(8'h41);
    model_u.send(CHAR_CR);
    repeat (20) @(negedge clk_sys);
    chk({7'h0, rv}, 8'h00);
  endtask : t_mode_off
  // String held during the pulse; control codes dropped.
  task automatic t_pulse();
    mode_on();
    rp = 1;
    model_u.send(8'h41);
    model_u.send(8'h01);
    model_u.send(8'h7E);
    model_u.send(CHAR_DEL);
    model_u.send(CHAR_CR);
    repeat (50) @(negedge clk_sys);
    chk({7'h0, rv}, 8'h00);
    rp = 0;
    take('{8'h41, 8'h7E}, 1'b1);
  endtask : t_pulse
  // Overlong string is clipped; the clear strobe then turns the mode off.
  task automatic t_long();
    logic [7:0] e[$];
    ee = 0;
    for (int k = 0; k < MAX_CHARS + 2; k++) begin
      model_u.send(8'h30 + 8'(k % 10));
      if (k < MAX_CHARS) e.push_back(8'h30 + 8'(k % 10));
    end
    model_u.send(CHAR_CR);
    take(e, 1'b0);
    mc = 1;
    @(negedge clk_sys);
    mc = 0;
    chk({7'h0, mode}, 8'h00);
  endtask : t_long
  // A terminator while a result waits drops the new string; a bare one sends nothing.
  task automatic t_drop();
    mode_on();
    rp = 1;
    model_u.send(8'h43);
    model_u.send(CHAR_CR);
    model_u.send(8'h44);
    model_u.send(CHAR_CR);
    model_u.send(CHAR_CR);
    rp = 0;
    take('{8'h43}, 1'b0);
    repeat (20) @(negedge clk_sys);
    chk({7'h0, rv}, 8'h00);
  endtask : t_drop
  // Reset in mid-string drops it and the mode.
  task automatic t_midreset();
    mode_on();
    model_u.send(8'h42);
    rstn = 0;
    @(negedge clk_sys);
    chk({7'h0, mode}, 8'h00);
    chk({2'h0, hl}, 8'h00);
    rstn = 1;
    model_u.send(CHAR_CR);
    repeat (20) @(negedge clk_sys);
    chk({7'h0, rv}, 8'h00);
  endtask : t_midreset
  initial begin
    repeat (2) @(negedge clk_sys);
    rstn = 1;
    @(negedge clk_sys);
    t_mode_off();
    t_pulse();
    t_long();
    t_drop();
    t_midreset();
    tally_and_finish();
  end
endmodule : aux_serial_result_injector_tb_top
`default_nettype wire

/* File: aux_term_model.sv */
`timescale 1ns/1ps
`default_nettype none
module aux_term_model #(
  parameter int unsigned BIT_CYC = 8
) (
  // Bit timing clock.
  input wire logic clk_sys,
  // Line towards the block, idle high.
  output var logic txd
);
  initial txd = 1'b1;
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int b = 0; b < 10; b++) begin
      @(negedge clk_sys);
      txd = f[b];
      repeat (BIT_CYC - 1) @(negedge clk_sys);
    end
  endtask : send
endmodule : aux_term_model
`default_nettype wire

/* File: aux_uart_rx.sv */
`timescale 1ns/1ps
`default_nettype none
// Receives 8N1 characters from the terminal line; one-cycle strobe per byte.
module aux_uart_rx
  import aux_pkg::*;
#(
  parameter int unsigned BIT_CYC = BIT_CYCLES
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Serial line.
  input wire logic rxd,
  // Received character.
  output logic [7:0] rx_data,
  output logic rx_valid
);
  // Bit timer, bit index and shift register.
  logic [15:0] cnt_reg;
  logic [3:0] bit_reg;
  logic busy_reg;
  logic [7:0] shift_reg;

  // Frame sampling: start found at the falling edge, bits sampled mid-cell.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 16'h0000;
      bit_reg <= 4'h0;
      busy_reg <= 1'b0;
      shift_reg <= 8'h00;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!busy_reg) begin
        // Wait for the start bit; first sample lands in its middle.
        if (!rxd) begin
          busy_reg <= 1'b1;
          cnt_reg <= 16'(BIT_CYC / 2);
          bit_reg <= 4'h0;
        end
      end else if (cnt_reg != 16'h0000) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end else begin
        cnt_reg <= 16'(BIT_CYC - 1);
        bit_reg <= bit_reg + 4'h1;
        if (bit_reg == 4'h0) begin
          // A start bit that is high again was a glitch.
          if (rxd) begin
            busy_reg <= 1'b0;
          end
        end else if (bit_reg <= 4'(DATA_BITS)) begin
          shift_reg <= {rxd, shift_reg[7:1]};
        end else begin
          // Stop bit: a framing error drops the character.
          busy_reg <= 1'b0;
          if (rxd) begin
            rx_data <= shift_reg;
            rx_valid <= 1'b1;
          end
        end
      end
    end
  end
endmodule : aux_uart_rx
`default_nettype wire
